// ==== hdl/iosr_pkg.sv ====
// Package of constants and types for the I/O sample reporter
package iosr_pkg;
  // Sizes
  localparam int          NUM_LINES      = 15;  // Digital lines 0..14
  localparam int          NUM_ANALOG     = 4;   // Analog inputs 0..3
  localparam int          REC_MAX        = 26;  // Record buffer size; longest record, text form included, is 25
  localparam int          ADC_BITS       = 10;  // Unsigned analog code width
  // Register word indices
  localparam logic [7:0]  OFS_COMMAND    = 8'h00;
  localparam logic [7:0]  OFS_CONFIG     = 8'h01;
  localparam logic [7:0]  OFS_FRAMED     = 8'h02;
  localparam logic [7:0]  OFS_INTERVAL   = 8'h03;
  localparam logic [7:0]  OFS_CHG_MASK   = 8'h04;
  localparam logic [7:0]  OFS_DEST_HIGH  = 8'h05;
  localparam logic [7:0]  OFS_DEST_LOW   = 8'h06;
  localparam logic [7:0]  OFS_WAKE_TIME  = 8'h07;
  localparam logic [7:0]  OFS_PULL_EN    = 8'h08;
  localparam logic [7:0]  OFS_PULL_DIR   = 8'h09;
  localparam logic [7:0]  OFS_STATUS     = 8'h0A;
  localparam logic [7:0]  OFS_LINE_BASE  = 8'h10;  // Line n config at base + n
  // Command register bit positions
  localparam int          CMD_QUERY_BIT  = 0;
  localparam int          CMD_APPLY_BIT  = 1;
  localparam int          CMD_EXIT_BIT   = 2;
  // Config register bit positions
  localparam int          CFG_SUPPLY_BIT = 0;
  localparam int          CFG_SLEEP_BIT  = 1;
  // Pin configuration codes
  localparam logic [2:0]  PIN_DISABLED   = 3'h0;
  localparam logic [2:0]  PIN_PERIPH     = 3'h1;
  localparam logic [2:0]  PIN_ANALOG     = 3'h2;
  localparam logic [2:0]  PIN_DIN        = 3'h3;
  localparam logic [2:0]  PIN_DOUT_LOW   = 3'h4;
  localparam logic [2:0]  PIN_DOUT_HIGH  = 3'h5;
  // Record field values and positions
  localparam logic [7:0]  SAMPLE_SETS    = 8'h01;
  localparam int          SUPPLY_BIT     = 7;
  localparam int          PULL_LINE1_BIT = 3;
  localparam logic [7:0]  CR_BYTE        = 8'h0D;
  // Reset values
  localparam logic [2:0]  RST_LINE_CFG   = 3'h0;
  localparam logic [15:0] RST_INTERVAL   = 16'h0000;
  localparam logic [14:0] RST_CHG_MASK   = 15'h0000;
  localparam logic [31:0] RST_DEST       = 32'h0000_0000;
  localparam logic [15:0] RST_WAKE_TIME  = 16'h0000;
  localparam logic [14:0] RST_PULL       = 15'h0000;
  localparam logic [1:0]  RST_FRAMED     = 2'h0;
  // Timing
  localparam int          MS_NS          = 1000000;  // One millisecond
  localparam int          CLK_PERIOD_NS  = 8;        // sys_clk period
  localparam int          MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
  // Sequencer states
  typedef enum logic {ST_IDLE, ST_EMIT} iosr_state_type;
  // One outgoing record byte with its routing
  typedef struct packed {
    logic [7:0]  data;      // Record byte
    logic        last;      // Final byte of record
    logic        to_radio;  // Over the air, else local serial
    logic        framed;    // Framed response, else text list
    logic [63:0] addr;      // Radio destination, zero is coordinator
  } iosr_byte_type;
endpackage

// ==== hdl/iosr_reporter.sv ====
// I/O sample reporter: pin setup, triggers, record emission
`timescale 1ns/10ps
`default_nettype none
module iosr_reporter #(
  parameter int MS_CYCLES_P = iosr_pkg::MS_CYCLES  // Clocks per millisecond
) (
  input  wire logic               sys_clk,
  input  wire logic               srst,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  input  wire logic [14:0]        dio_in,
  input  wire logic [39:0]        adc_codes,
  input  wire logic [9:0]         supply_code,
  output logic [14:0]             dio_out,
  output logic [14:0]             dio_oe_n,
  output logic [14:0]             analog_sel,
  output logic [14:0]             periph_sel,
  output logic                    line1_pull_en,
  output logic [14:0]             pull_up_en,
  output logic [14:0]             pull_down_en,
  input  wire logic               remote_query,
  input  wire logic [63:0]        remote_src_addr,
  input  wire logic               wake_start,
  output logic                    awake,
  input  wire logic               rx_sample_valid,
  input  wire logic [7:0]         rx_sample_data,
  output logic                    fwd_valid,
  output logic [7:0]              fwd_data,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output iosr_pkg::iosr_byte_type out_byte
);
  import iosr_pkg::*;

  localparam int MSW = $clog2(MS_CYCLES_P + 1);  // Millisecond counter width
  localparam int IXW = $clog2(REC_MAX + 1);      // Record index width

  // Pending (written) and active (applied) pin settings
  logic [2:0]     cfg_pend_r [NUM_LINES];
  logic [2:0]     cfg_act_r  [NUM_LINES];
  logic [14:0]    pull_en_pend_r;        // Written pull enables
  logic [14:0]    pull_dir_pend_r;       // Written pull directions
  logic [14:0]    pull_en_act_r;         // Applied pull enables
  logic [14:0]    pull_dir_act_r;        // Applied pull directions
  // Direct settings
  logic           supply_en_r;           // Include supply reading
  logic           sleep_en_r;            // Sleep-enabled device
  logic [1:0]     framed_mode_select_r;  // Zero is transparent/text
  logic [15:0]    periodic_interval_ms_r;
  logic [14:0]    change_monitor_mask_r;
  logic [31:0]    dest_addr_high_r;
  logic [31:0]    dest_addr_low_r;
  logic [15:0]    wake_time_r;
  // Trigger state
  logic           query_pend_r;          // Query waiting
  logic           query_remote_r;        // Query came over the air
  logic [63:0]    query_src_r;           // Requester address
  logic           change_pend_r;         // Change seen
  logic           periodic_pend_r;       // Interval elapsed
  logic [14:0]    last_level_r;          // Levels at last sample
  logic [MSW-1:0] ms_cnt_r;              // Cycles within a millisecond
  logic [15:0]    period_cnt_r;          // Milliseconds into current interval
  logic [15:0]    wake_cnt_r;            // Milliseconds left awake
  // Emission state
  iosr_state_type state_r;
  logic [7:0]     rec_r [REC_MAX];       // Record being shifted out
  logic [IXW-1:0] left_r;                // Bytes still to send
  logic           rec_radio_r;
  logic           rec_framed_r;
  logic [63:0]    rec_addr_r;

  logic [14:0]    dig_mask;              // Lines counting as digital
  logic [3:0]     ana_mask;              // Analog inputs enabled
  logic [7:0]     ana_byte;              // Analog mask byte
  logic           any_input;             // Something to sample
  logic           ms_tick;               // One pulse per millisecond
  logic           chg_seen;              // Monitored line differs
  logic           start;                 // Record captured this cycle
  logic           take;                  // Sink accepts a byte
  logic           is_query;              // Current trigger is a query
  logic           text_form;             // CR-separated answer
  logic [7:0]     bld [REC_MAX];         // Record under construction
  logic [IXW-1:0] bld_n;                 // Its length
  logic [14:0]    last_nxt;

  // Per-line decode of applied configuration
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      assign dig_mask[g]   = (cfg_act_r[g] == PIN_DIN) || (cfg_act_r[g] == PIN_DOUT_LOW) ||
                             (cfg_act_r[g] == PIN_DOUT_HIGH);
      assign dio_out[g]    = (cfg_act_r[g] == PIN_DOUT_HIGH);
      assign dio_oe_n[g]   = !((cfg_act_r[g] == PIN_DOUT_LOW) ||
                               (cfg_act_r[g] == PIN_DOUT_HIGH));
      assign analog_sel[g] = (cfg_act_r[g] == PIN_ANALOG);
      assign periph_sel[g] = (cfg_act_r[g] == PIN_PERIPH);
    end
    for (g = 0; g < NUM_ANALOG; g++) begin : g_ana
      assign ana_mask[g] = (cfg_act_r[g] == PIN_ANALOG);
    end
  endgenerate

  // Pulls follow applied masks; direction counts only when pulled
  assign line1_pull_en = pull_en_act_r[PULL_LINE1_BIT];
  assign pull_up_en    = pull_en_act_r & pull_dir_act_r;
  assign pull_down_en  = pull_en_act_r & ~pull_dir_act_r;

  assign ana_byte  = {supply_en_r, 3'h0, ana_mask};
  assign any_input = (dig_mask != 15'h0000) || (ana_byte != 8'h00);
  assign ms_tick   = (ms_cnt_r == MSW'(MS_CYCLES_P - 1));
  assign chg_seen  = ((dio_in ^ last_level_r) & change_monitor_mask_r) != 15'h0000;
  assign awake     = !sleep_en_r || (wake_cnt_r != 16'h0000);
  assign start     = (state_r == ST_IDLE) && any_input &&
                     (query_pend_r || change_pend_r || periodic_pend_r);
  assign take      = (state_r == ST_EMIT) && out_ready;
  assign is_query  = query_pend_r;
  // Local transparent query answers as text
  assign text_form = is_query && !query_remote_r && (framed_mode_select_r == 2'h0);

  // Record built from live pins
  always_comb begin
    bld_n = '0;
    for (int i = 0; i < REC_MAX; i++) begin
      bld[i] = 8'h00;
    end
    bld[bld_n] = SAMPLE_SETS;
    bld_n = bld_n + 1'b1;
    if (text_form) begin
      bld[bld_n] = CR_BYTE;
      bld_n = bld_n + 1'b1;
    end
    bld[bld_n] = {1'b0, dig_mask[14:8]};
    bld[bld_n + 1'b1] = dig_mask[7:0];
    bld_n = bld_n + 2'd2;
    if (text_form) begin
      bld[bld_n] = CR_BYTE;
      bld_n = bld_n + 1'b1;
    end
    bld[bld_n] = ana_byte;
    bld_n = bld_n + 1'b1;
    if (text_form) begin
      bld[bld_n] = CR_BYTE;
      bld_n = bld_n + 1'b1;
    end
    // States sent raw; only mask bits are meaningful to the receiver
    if (dig_mask != 15'h0000) begin
      bld[bld_n] = {1'b0, dio_in[14:8]};
      bld[bld_n + 1'b1] = dio_in[7:0];
      bld_n = bld_n + 2'd2;
      if (text_form) begin
        bld[bld_n] = CR_BYTE;
        bld_n = bld_n + 1'b1;
      end
    end
    for (int a = 0; a <= NUM_ANALOG; a++) begin
      if ((a < NUM_ANALOG) ? ana_mask[a] : supply_en_r) begin
        // Ten-bit code, zero-extended big endian
        bld[bld_n] = (a < NUM_ANALOG) ? {6'h00, adc_codes[a*ADC_BITS+8 +: 2]}
                                      : {6'h00, supply_code[9:8]};
        bld[bld_n + 1'b1] = (a < NUM_ANALOG) ? adc_codes[a*ADC_BITS +: 8]
                                             : supply_code[7:0];
        bld_n = bld_n + 2'd2;
        if (text_form) begin
          bld[bld_n] = CR_BYTE;
          bld_n = bld_n + 1'b1;
        end
      end
    end
  end

  // Register writes; command bits act as one-shot strobes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      supply_en_r            <= 1'b0;
      sleep_en_r             <= 1'b0;
      framed_mode_select_r   <= RST_FRAMED;
      periodic_interval_ms_r <= RST_INTERVAL;
      change_monitor_mask_r  <= RST_CHG_MASK;
      dest_addr_high_r       <= RST_DEST;
      dest_addr_low_r        <= RST_DEST;
      wake_time_r            <= RST_WAKE_TIME;
      pull_en_pend_r         <= RST_PULL;
      pull_dir_pend_r        <= RST_PULL;
      for (int i = 0; i < NUM_LINES; i++) begin
        cfg_pend_r[i] <= RST_LINE_CFG;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_CONFIG: begin
          supply_en_r <= reg_wdata[CFG_SUPPLY_BIT];
          sleep_en_r  <= reg_wdata[CFG_SLEEP_BIT];
        end
        OFS_FRAMED:    framed_mode_select_r   <= reg_wdata[1:0];
        OFS_INTERVAL:  periodic_interval_ms_r <= reg_wdata[15:0];
        OFS_CHG_MASK:  change_monitor_mask_r  <= reg_wdata[14:0];
        OFS_DEST_HIGH: dest_addr_high_r       <= reg_wdata;
        OFS_DEST_LOW:  dest_addr_low_r        <= reg_wdata;
        OFS_WAKE_TIME: wake_time_r            <= reg_wdata[15:0];
        OFS_PULL_EN:   pull_en_pend_r         <= reg_wdata[14:0];
        OFS_PULL_DIR:  pull_dir_pend_r        <= reg_wdata[14:0];
        default: begin
          // Line configs in a window; only 3 bits stored
          if ((reg_addr >= OFS_LINE_BASE) && (reg_addr < OFS_LINE_BASE + 8'(NUM_LINES))) begin
            cfg_pend_r[4'(reg_addr - OFS_LINE_BASE)] <= reg_wdata[2:0];
          end
        end
      endcase
    end
  end

  // Pin settings move to the pins only on apply or exit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pull_en_act_r  <= RST_PULL;
      pull_dir_act_r <= RST_PULL;
      for (int i = 0; i < NUM_LINES; i++) begin
        cfg_act_r[i] <= RST_LINE_CFG;
      end
    end else if (reg_wr && (reg_addr == OFS_COMMAND) &&
                 (reg_wdata[CMD_APPLY_BIT] || reg_wdata[CMD_EXIT_BIT])) begin
      pull_en_act_r  <= pull_en_pend_r;
      pull_dir_act_r <= pull_dir_pend_r;
      for (int i = 0; i < NUM_LINES; i++) begin
        cfg_act_r[i] <= cfg_pend_r[i];
      end
    end
  end

  // Register reads, one cycle later; unmapped reads as zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CONFIG:    reg_rdata <= {30'h0, sleep_en_r, supply_en_r};
        OFS_FRAMED:    reg_rdata <= {30'h0, framed_mode_select_r};
        OFS_INTERVAL:  reg_rdata <= {16'h0000, periodic_interval_ms_r};
        OFS_CHG_MASK:  reg_rdata <= {17'h0, change_monitor_mask_r};
        OFS_DEST_HIGH: reg_rdata <= dest_addr_high_r;
        OFS_DEST_LOW:  reg_rdata <= dest_addr_low_r;
        OFS_WAKE_TIME: reg_rdata <= {16'h0000, wake_time_r};
        OFS_PULL_EN:   reg_rdata <= {17'h0, pull_en_pend_r};
        OFS_PULL_DIR:  reg_rdata <= {17'h0, pull_dir_pend_r};
        // Status: busy, awake, analog mask, digital mask in use
        OFS_STATUS:    reg_rdata <= {6'h00, state_r == ST_EMIT, awake, ana_byte, 1'b0, dig_mask};
        default: begin
          if ((reg_addr >= OFS_LINE_BASE) && (reg_addr < OFS_LINE_BASE + 8'(NUM_LINES))) begin
            reg_rdata <= {29'h0, cfg_pend_r[4'(reg_addr - OFS_LINE_BASE)]};
          end else begin
            reg_rdata <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // Millisecond tick, interval and wake timers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ms_cnt_r     <= '0;
      period_cnt_r <= 16'h0000;
      wake_cnt_r   <= 16'h0000;
    end else begin
      ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
      if (wake_start) begin
        wake_cnt_r <= wake_time_r;
      end else if (ms_tick && (wake_cnt_r != 16'h0000)) begin
        wake_cnt_r <= wake_cnt_r - 1'b1;
      end
      // Zero interval or asleep holds the count at zero
      if ((periodic_interval_ms_r == 16'h0000) || !awake) begin
        period_cnt_r <= 16'h0000;
      end else if (ms_tick) begin
        period_cnt_r <= (period_cnt_r + 1'b1 >= periodic_interval_ms_r) ? 16'h0000
                                                                     : period_cnt_r + 1'b1;
      end
    end
  end

  // Trigger flags; set wins over the capture clear, except for the change flag
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      query_pend_r    <= 1'b0;
      query_remote_r  <= 1'b0;
      query_src_r     <= 64'h0;
      change_pend_r   <= 1'b0;
      periodic_pend_r <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == OFS_COMMAND) && reg_wdata[CMD_QUERY_BIT]) begin
        query_pend_r   <= 1'b1;
        query_remote_r <= 1'b0;
      end else if (remote_query) begin
        query_pend_r   <= 1'b1;
        query_remote_r <= 1'b1;
        query_src_r    <= remote_src_addr;
      end else if (start && is_query) begin
        query_pend_r <= 1'b0;
      end
      // Level seen at capture is already in the record
      if (chg_seen && (change_monitor_mask_r != 15'h0000) &&
          !(start && !is_query)) begin
        change_pend_r <= 1'b1;
      end else if (start && !is_query) begin
        change_pend_r <= 1'b0;
      end
      if ((periodic_interval_ms_r != 16'h0000) && awake && ms_tick &&
          (period_cnt_r + 1'b1 >= periodic_interval_ms_r)) begin
        periodic_pend_r <= 1'b1;
      end else if (start && !is_query) begin
        periodic_pend_r <= 1'b0;
      end
    end
  end

  // Stored levels refresh at capture
  always_comb begin
    last_nxt = start ? dio_in : last_level_r;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      last_level_r <= 15'h0000;
    end else begin
      last_level_r <= last_nxt;
    end
  end

  // Capture and shift out the record
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r      <= ST_IDLE;
      left_r       <= '0;
      rec_radio_r  <= 1'b0;
      rec_framed_r <= 1'b0;
      rec_addr_r   <= 64'h0;
      for (int i = 0; i < REC_MAX; i++) begin
        rec_r[i] <= 8'h00;
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_EMIT;
            left_r  <= bld_n;
            for (int i = 0; i < REC_MAX; i++) begin
              rec_r[i] <= bld[i];
            end
            rec_framed_r <= !text_form;
            if (is_query) begin
              rec_radio_r <= query_remote_r;
              rec_addr_r  <= query_remote_r ? query_src_r : 64'h0;
            end else begin
              rec_radio_r <= 1'b1;
              rec_addr_r  <= {dest_addr_high_r, dest_addr_low_r};
            end
          end
        end
        ST_EMIT: begin
          if (take) begin
            for (int i = 0; i < REC_MAX - 1; i++) begin
              rec_r[i] <= rec_r[i+1];
            end
            rec_r[REC_MAX-1] <= 8'h00;
            left_r <= left_r - 1'b1;
            if (left_r == IXW'(1)) begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign out_valid         = (state_r == ST_EMIT);
  assign out_byte.data     = rec_r[0];
  assign out_byte.last     = (left_r == IXW'(1));
  assign out_byte.to_radio = rec_radio_r;
  assign out_byte.framed   = rec_framed_r;
  assign out_byte.addr     = rec_addr_r;

  // Remote samples reach serial only in framed mode
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fwd_valid <= 1'b0;
      fwd_data  <= 8'h00;
    end else begin
      fwd_valid <= rx_sample_valid && (framed_mode_select_r != 2'h0);
      fwd_data  <= rx_sample_data;
    end
  end
endmodule // iosr_reporter
`default_nettype wire

// ==== tb/iosr_reporter_props.sv ====
// Checker of the I/O sample reporter ports
`timescale 1ns/10ps
`default_nettype none
module iosr_reporter_props (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_rd,
  input  wire logic [31:0]             reg_rdata,
  input  wire logic [14:0]             dio_out,
  input  wire logic [14:0]             dio_oe_n,
  input  wire logic [14:0]             analog_sel,
  input  wire logic                    line1_pull_en,
  input  wire logic [14:0]             pull_up_en,
  input  wire logic [14:0]             pull_down_en,
  input  wire logic                    rx_sample_valid,
  input  wire logic [7:0]              rx_sample_data,
  input  wire logic                    fwd_valid,
  input  wire logic [7:0]              fwd_data,
  input  wire logic                    out_valid,
  input  wire logic                    out_ready,
  input  wire iosr_pkg::iosr_byte_type out_byte
);
  import iosr_pkg::*;
  // One clock domain, sync reset
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  byte_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("byte moved in stall");
  first_count_a: assert property ($rose(out_valid) |-> out_byte.data == SAMPLE_SETS)
    else $error("no set count first");
  rec_end_a: assert property (out_valid && out_ready && out_byte.last |=> !out_valid)
    else $error("byte after last");
  fwd_copy_a: assert property (fwd_valid |-> $past(rx_sample_valid) && fwd_data == $past(rx_sample_data))
    else $error("stray forward");
  drive_high_a: assert property ((dio_out & dio_oe_n) == 15'h0000)
    else $error("undriven high");
  analog_drive_a: assert property ((analog_sel & ~dio_oe_n) == 15'h0000)
    else $error("analog driven");
  pull_line1_a: assert property (line1_pull_en == (pull_up_en[3] | pull_down_en[3]))
    else $error("line 1 pull wrong");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h0B |=> reg_rdata == 32'h0)
    else $error("unmapped read");
  local_route_a: assert property (out_valid && !out_byte.to_radio |-> out_byte.addr == 64'h0)
    else $error("local addressed");
endmodule // iosr_reporter_props
bind iosr_reporter iosr_reporter_props i_props (.sys_clk(sys_clk), .srst(srst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dio_out(dio_out),
  .dio_oe_n(dio_oe_n), .analog_sel(analog_sel), .line1_pull_en(line1_pull_en),
  .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .rx_sample_valid(rx_sample_valid),
  .rx_sample_data(rx_sample_data), .fwd_valid(fwd_valid), .fwd_data(fwd_data),
  .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte));
`default_nettype wire

// ==== tb/iosr_reporter_tb.sv ====
// Self-checking bench of the I/O sample reporter
`timescale 1ns/10ps
`default_nettype none
module iosr_reporter_tb;
  import iosr_pkg::*;
  logic        sys_clk, srst, reg_wr, reg_rd, remote_query, rx_sample_valid, stall;
  logic [7:0]  reg_addr, rx_sample_data, fwd_data, exp_q[$];
  logic [31:0] reg_wdata, reg_rdata;
  logic [14:0] dio_in, dio_out, dio_oe_n, analog_sel, pull_up_en, pull_down_en, oe, pe;
  logic [39:0] adc_codes;
  logic [9:0]  supply_code;
  logic [63:0] remote_src_addr, src;
  logic        line1_pull_en, fwd_valid, out_valid, out_ready, sup_en, txt, rq;
  logic [2:0]  cfg[15];
  logic [1:0]  fr;
  iosr_byte_type out_byte;
  int          error_cnt, checks, cyc;
  // Short ms for periodic tests
  iosr_reporter #(.MS_CYCLES_P(10)) i_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dio_in(dio_in), .adc_codes(adc_codes), .supply_code(supply_code), .dio_out(dio_out),
    .dio_oe_n(dio_oe_n), .analog_sel(analog_sel), .periph_sel(), .line1_pull_en(line1_pull_en),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .remote_query(remote_query),
    .remote_src_addr(remote_src_addr), .wake_start(1'b0), .awake(),
    .rx_sample_valid(rx_sample_valid), .rx_sample_data(rx_sample_data), .fwd_valid(fwd_valid),
    .fwd_data(fwd_data), .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte));
  iosr_sink_model i_sink (.sys_clk(sys_clk), .stall(stall), .out_valid(out_valid),
    .out_ready(out_ready), .out_byte(out_byte));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Random sink stalls; hang guard
  always @(posedge sys_clk) begin
    stall <= 1'($urandom_range(1));
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic chk(input logic [63:0] seen, exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Write, then an idle cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk(reg_rdata, e, "reg_rdata");
  endtask
  // Field, then CR in text form
  function automatic void put(input logic [15:0] v, input bit two);
    if (two) exp_q.push_back(v[15:8]);
    exp_q.push_back(v[7:0]);
    if (txt) exp_q.push_back(CR_BYTE);
  endfunction
  // Expected record from applied config and inputs
  function automatic void mk();
    logic [14:0] dm;
    logic [7:0]  am;
    am = {sup_en, 7'h00};
    foreach (cfg[i]) dm[i] = cfg[i] inside {PIN_DIN, PIN_DOUT_LOW, PIN_DOUT_HIGH};
    for (int i = 0; i < 4; i++) am[i] = cfg[i] == PIN_ANALOG;
    exp_q = {};
    put(16'(SAMPLE_SETS), 0);
    put({1'b0, dm}, 1);
    put({8'h00, am}, 0);
    if (dm != 15'h0000) put({1'b0, dio_in}, 1);
    for (int i = 0; i < 4; i++) if (am[i]) put({6'h00, adc_codes[10*i +: 10]}, 1);
    if (sup_en) put({6'h00, supply_code}, 1);
  endfunction
  // Waits for a record, compares byte by byte
  task automatic rec(input logic rad, input logic [63:0] ad);
    for (int n = 0; n < 600 && i_sink.recs == 0; n++) @(posedge sys_clk);
    chk(i_sink.got.size(), exp_q.size(), "record length");
    foreach (exp_q[i]) if (i < i_sink.got.size()) chk(i_sink.got[i].data, exp_q[i], "byte");
    chk({i_sink.got[0].to_radio, i_sink.got[0].addr}, {rad, ad}, "route");
    i_sink.got = {};
    i_sink.recs = 0;
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {reg_wr, reg_rd, remote_query, rx_sample_valid, srst} = 5'h01;
    {reg_addr, reg_wdata, rx_sample_data, dio_in, adc_codes} = 'h0;
    {supply_code, remote_src_addr} = 'h0;
    oe = 15'h7FFF;
    void'($urandom(46));
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rdc(OFS_STATUS, 32'h0100_0000);
    rdc(8'h0B, 32'h0);
    // No input: query yields nothing; reset drops it
    wr(OFS_COMMAND, 32'h1);
    repeat (60) @(posedge sys_clk);
    chk(i_sink.got.size(), 0, "records");
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    // Random pin setups, local and remote queries
    for (int k = 0; k < 8; k++) begin
      foreach (cfg[i]) cfg[i] = 3'($urandom_range(5));
      cfg[0] = 3'($urandom_range(5, 2));
      sup_en = 1'($urandom_range(1));
      fr = 2'($urandom_range(2));
      pe = 15'($urandom);
      src = {$urandom, $urandom};
      foreach (cfg[i]) wr(OFS_LINE_BASE + 8'(i), {29'h0, cfg[i]});
      wr(OFS_CONFIG, {31'h0, sup_en});
      wr(OFS_FRAMED, {30'h0, fr});
      wr(OFS_PULL_EN, {17'h0, pe});
      chk(dio_oe_n, oe, "oe early");
      wr(OFS_COMMAND, k[0] ? 32'h4 : 32'h2);
      @(posedge sys_clk);
      foreach (cfg[i]) oe[i] = !(cfg[i] inside {PIN_DOUT_LOW, PIN_DOUT_HIGH});
      chk(dio_oe_n, oe, "dio_oe_n");
      foreach (cfg[i]) chk({dio_out[i], analog_sel[i]}, {cfg[i] == 5, cfg[i] == 2}, "pin");
      chk(line1_pull_en, pe[PULL_LINE1_BIT], "line1_pull_en");
      dio_in <= 15'($urandom);
      adc_codes <= {$urandom, $urandom};
      supply_code <= 10'($urandom);
      rq = 1'($urandom_range(1));
      remote_src_addr <= src;
      remote_query <= rq;
      @(posedge sys_clk);
      remote_query <= 1'b0;
      @(posedge sys_clk);
      if (!rq) wr(OFS_COMMAND, 32'h1);
      txt = !rq && fr == 2'h0;
      mk();
      rec(rq, rq ? src : 64'h0);
      rx_sample_data <= 8'($urandom);
      rx_sample_valid <= 1'b1;
      @(posedge sys_clk);
      rx_sample_valid <= 1'b0;
      @(negedge sys_clk);
      chk(fwd_valid, fr != 2'h0, "fwd_valid");
      @(posedge sys_clk);
    end
    // Monitored line change goes to the destination at once
    cfg[5] = PIN_DIN;
    wr(OFS_LINE_BASE + 8'h05, 32'h3);
    wr(OFS_COMMAND, 32'h2);
    wr(OFS_DEST_HIGH, src[63:32]);
    wr(OFS_DEST_LOW, src[31:0]);
    wr(OFS_CHG_MASK, 32'h20);
    dio_in[5] <= ~dio_in[5];
    @(posedge sys_clk);
    txt = 1'b0;
    mk();
    rec(1'b1, src);
    // Unmonitored change silent; periodic to coordinator
    dio_in[6] <= ~dio_in[6];
    wr(OFS_DEST_HIGH, 32'h0);
    wr(OFS_DEST_LOW, 32'h0);
    chk(i_sink.got.size(), 0, "records");
    mk();
    wr(OFS_INTERVAL, 32'h14);
    rec(1'b1, 64'h0);
    wr(OFS_INTERVAL, 32'h0);
    repeat (400) @(posedge sys_clk);
    chk(i_sink.got.size(), 0, "records");
    give_verdict();
  end
endmodule // iosr_reporter_tb
`default_nettype wire

// ==== tb/iosr_sink_model.sv ====
// Model of the serial port or radio that takes record bytes
`timescale 1ns/10ps
`default_nettype none
module iosr_sink_model (
  input  wire logic                    sys_clk,
  input  wire logic                    stall,
  input  wire logic                    out_valid,
  output logic                         out_ready,
  input  wire iosr_pkg::iosr_byte_type out_byte
);
  import iosr_pkg::*;
  iosr_byte_type got[$];  // Bytes taken, in order
  int            recs;    // Whole records taken
  // Takes a byte on a ready edge; stalls on request
  always @(posedge sys_clk) begin
    if (out_valid && out_ready) begin
      got.push_back(out_byte);
      if (out_byte.last) recs++;
    end
    out_ready <= !stall;
  end
endmodule // iosr_sink_model
`default_nettype wire
